// file: hw/bfp_ctrl.sv
/*
 * Fault-protection control for a buck regulator: severity sorting, reset
 * sequence, hiccup and latch-off handling, frequency-resistor check, and an
 * AXI4-Lite register slave.
 * Assumes detector inputs and the enable come from other clock domains.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
module bfp_ctrl
	import bfp_pkg::*;
#(
	parameter int HICCUP_CYC = BFP_HICCUP_CYC,
	parameter int RESET_BLANK_CYC = BFP_RESET_BLANK_CYC,
	parameter int FREQ_CHECK_CYC = BFP_FREQ_CHECK_CYC,
	parameter int OC_PAIRS = BFP_OC_PAIRS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire bfp_fault_t fault_in,
	input wire logic internal_enable,
	output bfp_power_t power_out,
	output logic host_irq
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		bfp_fault_t f1;
		bfp_fault_t f2;
		logic en1;
		logic en2;
		bfp_state_t st;
		logic [31:0] tmr;
		logic [2:0] oc_cnt;
		logic cbc_high_seen;
		logic uv_prev;
		logic uv_flag;
		logic ov_flag;
		logic oc_flag;
		logic freq_irq;
		logic uv_sel;
		logic uv_dis;
		logic resp_sel;
		logic uv_mask;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
	} bfp_regs_t;

	bfp_regs_t s_reg;
	bfp_regs_t s_next;

	function automatic logic known_ofs(input logic [7:0] a);
		known_ofs = (a == BFP_OFS_IRQ_FLAGS) || (a == BFP_OFS_FAULT_FLAGS) || (a == BFP_OFS_IRQ_MASK) ||
			(a == BFP_OFS_PROT_CTRL) || (a == BFP_OFS_UV_SEL) || (a == BFP_OFS_STATE);
	endfunction

	logic uv_below;
	logic lvl1;
	logic lvl2;
	logic lvl3;
	logic lvl4;
	logic oc_pair;
	logic oc_trip;
	logic tmr_done;
	logic do_wr;
	logic do_rd;
	logic [31:0] rd_word;

	always_comb begin
		// Synchronised detector view
		uv_below = s_reg.uv_sel ? s_reg.f2.uv_cv_below : s_reg.f2.uv_cc_below;
		oc_pair = s_reg.cbc_high_seen && s_reg.f2.cbc_low;
		oc_trip = oc_pair && (s_reg.oc_cnt == 3'(OC_PAIRS - 1));
		lvl1 = s_reg.f2.uvlo || s_reg.f2.ovlo;
		lvl2 = s_reg.f2.bias_oc || s_reg.f2.bias_ov || s_reg.f2.bias_uv || s_reg.f2.aux_uv ||
			s_reg.f2.hard_tsd;
		lvl3 = (uv_below && !s_reg.uv_dis && s_reg.resp_sel) || (s_reg.f2.sync_err && s_reg.resp_sel) ||
			s_reg.f2.out_ov || oc_trip;
		lvl4 = (uv_below && !s_reg.uv_dis && !s_reg.resp_sel) || (s_reg.f2.sync_err && !s_reg.resp_sel) ||
			s_reg.f2.soft_tsd;
		tmr_done = (s_reg.tmr == 32'h0000_0000);
		do_wr = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
		do_rd = s_axi_arvalid && !s_reg.rvalid;
		case (s_axi_araddr)
			BFP_OFS_IRQ_FLAGS: rd_word = {27'h0, s_reg.freq_irq, 4'h0};
			BFP_OFS_FAULT_FLAGS: rd_word = {25'h0, s_reg.oc_flag, s_reg.ov_flag, s_reg.uv_flag, 4'h0};
			BFP_OFS_IRQ_MASK: rd_word = {27'h0, s_reg.uv_mask, 4'h0};
			BFP_OFS_PROT_CTRL: rd_word = {28'h0, s_reg.uv_dis, s_reg.resp_sel, 2'h0};
			BFP_OFS_UV_SEL: rd_word = {28'h0, s_reg.uv_sel, 3'h0};
			BFP_OFS_STATE: rd_word = {29'h0, 3'(s_reg.st)};
			default: rd_word = 32'h0000_0000;
		endcase

		s_next = s_reg;
		s_next.f1 = fault_in;
		s_next.f2 = s_reg.f1;
		s_next.en1 = internal_enable;
		s_next.en2 = s_reg.en1;
		s_next.uv_prev = uv_below;
		if (!tmr_done) begin
			s_next.tmr = s_reg.tmr - 32'h1;
		end

		// Over-current pair counter, runs only while the converter switches
		if (s_reg.st != BFP_ST_RUN) begin
			s_next.oc_cnt = 3'h0;
			s_next.cbc_high_seen = 1'b0;
		end else if (s_reg.f2.cbc_high) begin
			s_next.cbc_high_seen = 1'b1;
		end else if (oc_pair) begin
			s_next.cbc_high_seen = 1'b0;
			s_next.oc_cnt = oc_trip ? 3'h0 : s_reg.oc_cnt + 3'h1;
		end

		// Severity-ordered sequencer
		if (lvl1) begin
			s_next.st = BFP_ST_LOCKOUT;
		end else if (lvl2) begin
			s_next.st = BFP_ST_BIAS_RESET;
			s_next.tmr = 32'(RESET_BLANK_CYC);
		end else begin
			case (s_reg.st)
				BFP_ST_LOCKOUT: begin
					s_next.st = BFP_ST_BIAS_RESET;
					s_next.tmr = 32'(RESET_BLANK_CYC);
				end
				BFP_ST_BIAS_RESET: begin
					if (tmr_done) begin
						s_next.st = BFP_ST_FREQ_CHECK;
						s_next.tmr = 32'(FREQ_CHECK_CYC);
					end
				end
				BFP_ST_FREQ_CHECK: begin
					if (tmr_done) begin
						if (s_reg.f2.freq_ok) begin
							s_next.st = BFP_ST_WAIT_EN;
						end else begin
							s_next.tmr = 32'(FREQ_CHECK_CYC);
						end
					end
				end
				BFP_ST_WAIT_EN: begin
					if (s_reg.en2) begin
						s_next.st = BFP_ST_RUN;
					end
				end
				BFP_ST_RUN: begin
					if (!s_reg.en2) begin
						s_next.st = BFP_ST_WAIT_EN;
					end else if (lvl3) begin
						s_next.st = BFP_ST_LATCHED;
					end else if (lvl4) begin
						s_next.st = BFP_ST_HICCUP;
						s_next.tmr = 32'(HICCUP_CYC);
					end
				end
				BFP_ST_HICCUP: begin
					if (lvl3) begin
						s_next.st = BFP_ST_LATCHED;
					end else if (tmr_done) begin
						s_next.st = BFP_ST_RUN;
					end
				end
				BFP_ST_LATCHED: begin
					if (!s_reg.en2) begin
						s_next.st = BFP_ST_WAIT_EN;
					end
				end
				default: s_next.st = BFP_ST_LOCKOUT;
			endcase
		end

		// AXI4-Lite write channel
		if (s_axi_awvalid && !s_reg.aw_got) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_got) begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = known_ofs(s_reg.aw_addr) ? BFP_RESP_OKAY : BFP_RESP_SLVERR;
			if (s_reg.w_strb[0]) begin
				case (s_reg.aw_addr)
					BFP_OFS_IRQ_FLAGS: if (s_reg.w_data[BFP_BIT_FREQ_IRQ]) s_next.freq_irq = 1'b0;
					BFP_OFS_FAULT_FLAGS: begin
						if (s_reg.w_data[BFP_BIT_UV_FLAG]) s_next.uv_flag = 1'b0;
						if (s_reg.w_data[BFP_BIT_OV_FLAG]) s_next.ov_flag = 1'b0;
						if (s_reg.w_data[BFP_BIT_OC_FLAG]) s_next.oc_flag = 1'b0;
					end
					BFP_OFS_IRQ_MASK: s_next.uv_mask = s_reg.w_data[BFP_BIT_UV_MASK];
					BFP_OFS_PROT_CTRL: begin
						s_next.uv_dis = s_reg.w_data[BFP_BIT_UV_DIS];
						s_next.resp_sel = s_reg.w_data[BFP_BIT_RESP_SEL];
					end
					BFP_OFS_UV_SEL: s_next.uv_sel = s_reg.w_data[BFP_BIT_UV_SEL];
					default: ;
				endcase
			end
		end

		// Flags set after clears so a coincident event wins
		if (uv_below && !s_reg.uv_prev) begin
			s_next.uv_flag = 1'b1;
		end
		if (s_reg.f2.out_ov) begin
			s_next.ov_flag = 1'b1;
		end
		if (oc_trip) begin
			s_next.oc_flag = 1'b1;
		end
		if (s_reg.st == BFP_ST_FREQ_CHECK && tmr_done && !s_reg.f2.freq_ok) begin
			s_next.freq_irq = 1'b1;
		end
		s_next.irq = (s_next.uv_flag && !s_next.uv_mask) || s_next.freq_irq;

		// AXI4-Lite read channel
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (do_rd) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_word;
			s_next.rresp = known_ofs(s_axi_araddr) ? BFP_RESP_OKAY : BFP_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.st <= BFP_ST_LOCKOUT;
			s_reg.uv_sel <= BFP_RST_UV_SEL;
			s_reg.uv_dis <= BFP_RST_UV_DIS;
			s_reg.resp_sel <= BFP_RST_RESP_SEL;
			s_reg.uv_mask <= BFP_RST_UV_MASK;
		end else begin
			s_reg <= s_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign s_axi_awready = !s_reg.aw_got;
	assign s_axi_wready = !s_reg.w_got;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign power_out.bias_on = (s_reg.st != BFP_ST_LOCKOUT) && (s_reg.st != BFP_ST_BIAS_RESET);
	assign power_out.main_on = (s_reg.st == BFP_ST_RUN);
	assign power_out.bias_ready = (s_reg.st == BFP_ST_WAIT_EN) || power_out.main_on ||
		(s_reg.st == BFP_ST_HICCUP) || (s_reg.st == BFP_ST_LATCHED);
	assign host_irq = s_reg.irq;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence hic_enter_s;
		s_reg.st == BFP_ST_RUN ##1 s_reg.st == BFP_ST_HICCUP;
	endsequence

	// Every entry into blanking starts from a full count
	sequence blank_enter_s;
		s_reg.st != BFP_ST_BIAS_RESET ##1 s_reg.st == BFP_ST_BIAS_RESET;
	endsequence

	// Severity levels; each check waives the more severe levels
	lockout_halts_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lvl1 |=> s_reg.st == BFP_ST_LOCKOUT ##1 !power_out.bias_on)
		else $error("lockout did not halt");
	lockout_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_LOCKOUT && !lvl1 && !lvl2 |=> s_reg.st == BFP_ST_BIAS_RESET)
		else $error("lockout exit wrong");
	reset_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!lvl1 && lvl2 |=> s_reg.st == BFP_ST_BIAS_RESET)
		else $error("reset sequence not entered");
	bias_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_BIAS_RESET && tmr_done && !lvl1 && !lvl2 |=> power_out.bias_on)
		else $error("bias not restarted");
	blank_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		blank_enter_s |-> !power_out.bias_on && s_reg.tmr == 32'(RESET_BLANK_CYC))
		else $error("blanking count wrong");
	latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_LATCHED && s_reg.en2 && !lvl1 && !lvl2 |=> !power_out.main_on)
		else $error("latch released while enabled");
	latch_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_RUN && s_reg.en2 && lvl3 && !lvl1 && !lvl2 |=> s_reg.st == BFP_ST_LATCHED)
		else $error("latch-off missed");

	// Under-voltage response choices
	uv_hiccup_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_RUN && s_reg.en2 && uv_below && !s_reg.uv_dis && !s_reg.resp_sel &&
		!lvl1 && !lvl2 && !lvl3 |=> s_reg.st == BFP_ST_HICCUP)
		else $error("uv hiccup missed");
	uv_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_RUN && s_reg.en2 && uv_below && !s_reg.uv_dis && s_reg.resp_sel &&
		!lvl1 && !lvl2 |=> s_reg.st == BFP_ST_LATCHED)
		else $error("uv latch-off missed");
	uv_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_RUN && s_reg.en2 && s_reg.uv_dis && !s_reg.f2.sync_err && !s_reg.f2.soft_tsd &&
		!s_reg.f2.out_ov && !oc_trip && !lvl1 && !lvl2 |=> s_reg.st == BFP_ST_RUN)
		else $error("disabled uv still acted");

	// Hiccup wait and retry
	hiccup_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hic_enter_s |-> !power_out.main_on && s_reg.tmr == 32'(HICCUP_CYC))
		else $error("hiccup wait wrong");
	hiccup_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_HICCUP && !tmr_done && !lvl1 && !lvl2 && !lvl3 |=> !power_out.main_on)
		else $error("hiccup ended early");
	hiccup_retry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_HICCUP && tmr_done && !lvl1 && !lvl2 && !lvl3 |=> power_out.main_on)
		else $error("hiccup retry missed");

	// Status flags and interrupt
	uv_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		uv_below && !s_reg.uv_prev |=> s_reg.uv_flag)
		else $error("uv flag not set");
	uv_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.uv_flag && !s_reg.uv_mask |-> host_irq)
		else $error("uv irq missing");
	oc_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		oc_trip |=> s_reg.oc_flag)
		else $error("oc flag not set");

	// Resistor validation before bias ready
	freq_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_FREQ_CHECK && tmr_done && !s_reg.f2.freq_ok && !lvl1 && !lvl2
		|=> s_reg.freq_irq && s_reg.st == BFP_ST_FREQ_CHECK)
		else $error("freq retry wrong");
	freq_irq_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.freq_irq |-> host_irq)
		else $error("freq irq missing");
	freq_main_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_FREQ_CHECK |-> !power_out.main_on && !power_out.bias_ready)
		else $error("main on during freq check");
	freq_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == BFP_ST_FREQ_CHECK && tmr_done && s_reg.f2.freq_ok && !lvl1 && !lvl2
		|=> s_reg.st == BFP_ST_WAIT_EN && power_out.bias_ready)
		else $error("freq check did not pass");

endmodule

// file: pkg/bfp_pkg.sv
/*
 * Package for the buck fault-protection control block: register map, field
 * positions, reset values, timing counts and shared types.
 * Assumes one 125 MHz clock and an AXI4-Lite master with 32-bit data.
 */
// Behaviour
// - Feedback below selected threshold triggers under-voltage
// - Under-voltage event sets sticky fault status bit
// - Select low picks CC threshold, high CV
// - Disable bit suppresses under-voltage protective action
// - Detector, flag and interrupt stay active when disabled
// - Mask bit blocks under-voltage interrupt
// - Response select low gives hiccup retry cycles
// - First hit stops switching for hiccup wait
// - Retry resumes if cleared, else repeats wait
// - Response select high latches converter off
// - Input lockouts halt everything but lockout detectors
// - Level one holds until both lockouts release
// - Bias or auxiliary faults, hard thermal: reset sequence
// - Stop bias, blank timer, then restart bias
// - Level three faults latch off until enable low
// - Latch holds while enable high; needs low-high
// - Level four faults: off for hiccup period, retry
// - Bad frequency resistor: revalidate forever, keep interrupting
// - Resistor checked only before bias-ready state
// - Four consecutive limit pairs trigger over-current, flag
package bfp_pkg;

	localparam logic [7:0] BFP_OFS_IRQ_FLAGS = 8'h04;
	localparam logic [7:0] BFP_OFS_FAULT_FLAGS = 8'h08;
	localparam logic [7:0] BFP_OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] BFP_OFS_PROT_CTRL = 8'h24;
	localparam logic [7:0] BFP_OFS_UV_SEL = 8'h2c;
	localparam logic [7:0] BFP_OFS_STATE = 8'h40;

	localparam int BFP_BIT_FREQ_IRQ = 4;
	localparam int BFP_BIT_UV_FLAG = 4;
	localparam int BFP_BIT_OV_FLAG = 5;
	localparam int BFP_BIT_OC_FLAG = 6;
	localparam int BFP_BIT_UV_MASK = 4;
	localparam int BFP_BIT_RESP_SEL = 2;
	localparam int BFP_BIT_UV_DIS = 3;
	localparam int BFP_BIT_UV_SEL = 3;

	localparam logic BFP_RST_UV_SEL = 1'b1;
	localparam logic BFP_RST_UV_DIS = 1'b0;
	localparam logic BFP_RST_RESP_SEL = 1'b0;
	localparam logic BFP_RST_UV_MASK = 1'b0;

	localparam int BFP_CLK_MHZ = 125;
	localparam int BFP_HICCUP_US = 1000;
	localparam int BFP_RESET_BLANK_US = 1000;
	localparam int BFP_FREQ_CHECK_US = 10;
	localparam int BFP_HICCUP_CYC = BFP_HICCUP_US * BFP_CLK_MHZ;
	localparam int BFP_RESET_BLANK_CYC = BFP_RESET_BLANK_US * BFP_CLK_MHZ;
	localparam int BFP_FREQ_CHECK_CYC = BFP_FREQ_CHECK_US * BFP_CLK_MHZ;
	localparam int BFP_OC_PAIRS = 4;

	localparam logic [1:0] BFP_RESP_OKAY = 2'b00;
	localparam logic [1:0] BFP_RESP_SLVERR = 2'b10;

	typedef enum {
		BFP_ST_LOCKOUT,
		BFP_ST_BIAS_RESET,
		BFP_ST_FREQ_CHECK,
		BFP_ST_WAIT_EN,
		BFP_ST_RUN,
		BFP_ST_HICCUP,
		BFP_ST_LATCHED
	} bfp_state_t;

	// Raw fault inputs from the analog detectors
	typedef struct packed {
		logic uvlo;
		logic ovlo;
		logic bias_oc;
		logic bias_ov;
		logic bias_uv;
		logic aux_uv;
		logic hard_tsd;
		logic soft_tsd;
		logic sync_err;
		logic out_ov;
		logic cbc_high;
		logic cbc_low;
		logic uv_cv_below;
		logic uv_cc_below;
		logic freq_ok;
	} bfp_fault_t;

	typedef struct packed {
		logic bias_on;
		logic main_on;
		logic bias_ready;
	} bfp_power_t;

endpackage

// file: test/bfp_host.sv
/*
 Host model: an AXI4-Lite master offering one write and one read task.
 Assumes the slave answers in its own time; the bench timeout ends a hang.
*/
module bfp_host (
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// file: test/tb.sv
/*
 Self-checking bench for the fault-protection control block.
 Assumes short hiccup and blanking counts; the host model drives the register bus.
*/
module tb import bfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, internal_enable, host_irq, mo_q;
	bfp_fault_t fault_in;
	bfp_power_t power_out;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int bad_count, n_tests, cyc, rises, fi;
	bfp_ctrl #(.HICCUP_CYC(20), .RESET_BLANK_CYC(20), .FREQ_CHECK_CYC(5), .OC_PAIRS(BFP_OC_PAIRS)) u_bfp_ctrl (.*);
	bfp_host u_bfp_host (.*);
	/****************/
	/* Helpers      */
	/****************/
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] bitv(input int b);
		return 32'h1 << b;
	endfunction
	function automatic logic [31:0] st(input bfp_state_t s);
		return 32'(s);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		u_bfp_host.rd(a, d, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_bfp_host.wr(a, v, r);
	endtask
	task automatic wst(input bfp_state_t e);
		for (int k = 0; k < 300; k++) begin
			rd(BFP_OFS_STATE);
			if (d === st(e)) break;
		end
		chk(d, st(e));
	endtask
	task automatic clk(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic relatch;
		internal_enable <= 1'b0;
		clk(6);
		internal_enable <= 1'b1;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Retry count lets the bench confirm hiccup retries repeat; cycle 40000 ends a hang
	always @(posedge aclk) begin
		mo_q <= power_out.main_on;
		if (power_out.main_on === 1'b1 && mo_q === 1'b0) rises++;
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			close_out;
		end
	end
	/****************/
	/* Scenarios    */
	/****************/
	initial begin
		aresetn = 1'b0;
		internal_enable = 1'b1;
		fault_in = '0;
		fault_in.uvlo = 1'b1;
		rnd = 32'h6d44;
		clk(10);
		aresetn <= 1'b1;
		wst(BFP_ST_LOCKOUT);
		fault_in.uvlo <= 1'b0;
		fault_in.ovlo <= 1'b1;
		clk(40);
		wst(BFP_ST_LOCKOUT);
		fault_in.ovlo <= 1'b0;
		clk(40);
		wst(BFP_ST_FREQ_CHECK);
		rd(BFP_OFS_IRQ_FLAGS);
		chk(d, bitv(BFP_BIT_FREQ_IRQ));
		chk(host_irq, 1'b1);
		fault_in.freq_ok <= 1'b1;
		wst(BFP_ST_RUN);
		wr(BFP_OFS_IRQ_FLAGS, bitv(BFP_BIT_FREQ_IRQ));
		fault_in.freq_ok <= 1'b0;
		clk(20);
		wst(BFP_ST_RUN);
		rd(BFP_OFS_IRQ_FLAGS);
		chk(d, 32'h0);
		fault_in.freq_ok <= 1'b1;
		$display("test 1 finished");
		rd(BFP_OFS_IRQ_MASK);
		chk(d, 32'(BFP_RST_UV_MASK) << BFP_BIT_UV_MASK);
		rd(BFP_OFS_PROT_CTRL);
		chk(d, 32'h0);
		rd(BFP_OFS_UV_SEL);
		chk(d, 32'(BFP_RST_UV_SEL) << BFP_BIT_UV_SEL);
		rd(8'h80);
		chk(r, BFP_RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr(BFP_OFS_IRQ_MASK, rnd);
			chk(r, BFP_RESP_OKAY);
			rd(BFP_OFS_IRQ_MASK);
			chk(d, rnd & bitv(BFP_BIT_UV_MASK));
		end
		wr(BFP_OFS_IRQ_MASK, 32'h0);
		$display("test 2 finished");
		fault_in.uv_cc_below <= 1'b1;
		clk(20);
		rd(BFP_OFS_FAULT_FLAGS);
		chk(d, 32'h0);
		fault_in.uv_cv_below <= 1'b1;
		wst(BFP_ST_HICCUP);
		rd(BFP_OFS_FAULT_FLAGS);
		chk(d, bitv(BFP_BIT_UV_FLAG));
		chk(host_irq, 1'b1);
		rises = 0;
		clk(150);
		chk(32'(rises >= 2), 32'h1);
		fault_in.uv_cv_below <= 1'b0;
		fault_in.uv_cc_below <= 1'b0;
		wst(BFP_ST_RUN);
		wr(BFP_OFS_FAULT_FLAGS, 32'h70);
		chk(host_irq, 1'b0);
		$display("test 3 finished");
		wr(BFP_OFS_PROT_CTRL, bitv(BFP_BIT_UV_DIS));
		fault_in.uv_cv_below <= 1'b1;
		clk(20);
		wst(BFP_ST_RUN);
		rd(BFP_OFS_FAULT_FLAGS);
		chk(d, bitv(BFP_BIT_UV_FLAG));
		chk(host_irq, 1'b1);
		wr(BFP_OFS_IRQ_MASK, bitv(BFP_BIT_UV_MASK));
		clk(3);
		chk(host_irq, 1'b0);
		fault_in.uv_cv_below <= 1'b0;
		wr(BFP_OFS_IRQ_MASK, 32'h0);
		wr(BFP_OFS_FAULT_FLAGS, 32'h70);
		$display("test 4 finished");
		wr(BFP_OFS_PROT_CTRL, bitv(BFP_BIT_RESP_SEL));
		wr(BFP_OFS_UV_SEL, 32'h0);
		fault_in.uv_cc_below <= 1'b1;
		wst(BFP_ST_LATCHED);
		fault_in.uv_cc_below <= 1'b0;
		clk(40);
		wst(BFP_ST_LATCHED);
		chk(power_out.main_on, 1'b0);
		relatch;
		wst(BFP_ST_RUN);
		wr(BFP_OFS_UV_SEL, bitv(BFP_BIT_UV_SEL));
		for (int j = 0; j < 2; j++) begin
			wr(BFP_OFS_PROT_CTRL, j ? bitv(BFP_BIT_RESP_SEL) : 32'h0);
			fault_in.sync_err <= 1'b1;
			wst(j ? BFP_ST_LATCHED : BFP_ST_HICCUP);
			fault_in.sync_err <= 1'b0;
			if (j) relatch;
			wst(BFP_ST_RUN);
		end
		$display("test 5 finished");
		for (int i = 0; i < BFP_OC_PAIRS; i++) begin
			if (i == BFP_OC_PAIRS - 1) wst(BFP_ST_RUN);
			fault_in.cbc_high <= 1'b1;
			clk(4);
			fault_in.cbc_high <= 1'b0;
			fault_in.cbc_low <= 1'b1;
			clk(4);
			fault_in.cbc_low <= 1'b0;
			clk(2);
		end
		wst(BFP_ST_LATCHED);
		rd(BFP_OFS_FAULT_FLAGS);
		chk(d & bitv(BFP_BIT_OC_FLAG), bitv(BFP_BIT_OC_FLAG));
		relatch;
		wst(BFP_ST_RUN);
		fault_in.soft_tsd <= 1'b1;
		wst(BFP_ST_HICCUP);
		fault_in.out_ov <= 1'b1;
		wst(BFP_ST_LATCHED);
		fault_in.soft_tsd <= 1'b0;
		fault_in.out_ov <= 1'b0;
		relatch;
		wst(BFP_ST_RUN);
		$display("test 6 finished");
		rnd = lfsr(rnd);
		for (int i = 0; i < 5; i++) begin
			fi = 12 - (i + int'(rnd[1:0])) % 5;
			fault_in[fi] <= 1'b1;
			wst(BFP_ST_BIAS_RESET);
			chk(power_out.bias_on, 1'b0);
			chk(power_out.bias_ready, 1'b0);
			fault_in[fi] <= 1'b0;
			wst(BFP_ST_RUN);
			chk(power_out.bias_ready, 1'b1);
		end
		fault_in.uvlo <= 1'b1;
		fault_in.bias_uv <= 1'b1;
		wst(BFP_ST_LOCKOUT);
		fault_in.uvlo <= 1'b0;
		fault_in.bias_uv <= 1'b0;
		wst(BFP_ST_RUN);
		$display("test 7 finished");
		close_out;
	end
endmodule
